// [mzam_pkg.sv]
// shared constants and carrier types for the multi-zone alarm monitor
package mzam_pkg;

  // clock and time base
  localparam int CLK_HZ         = 200_000_000;            // system clock rate
  localparam int MS_PER_S       = 1000;                   // milliseconds per second
  localparam int TICK_CYCLES    = CLK_HZ / MS_PER_S;      // cycles per 1 ms tick
  localparam int ALARM_DELAY_S  = 1;                      // alarm relay lag, seconds
  localparam int STOP_SHORT_S   = 60;                     // short stop delay, seconds
  localparam int STOP_LONG_S    = 180;                    // long stop delay, seconds
  localparam int ALARM_DELAY_MS = ALARM_DELAY_S * MS_PER_S;
  localparam int STOP_SHORT_MS  = STOP_SHORT_S * MS_PER_S;
  localparam int STOP_LONG_MS   = STOP_LONG_S * MS_PER_S;

  // widths
  localparam int ZONES  = 8;                              // alarm input zones
  localparam int SWITCH = 8;                              // configuration switches
  localparam int TICK_W = 18;                             // holds TICK_CYCLES
  localparam int CNT_W  = 18;                             // holds STOP_LONG_MS

  // switch positions (bit index, on = right = high)
  localparam int SW_IN_POL    = 0;                        // input active level
  localparam int SW_RELAY_POL = 1;                        // alarm relay polarity
  localparam int SW_OPT_POL   = 2;                        // option relay polarity
  localparam int SW_STOP_DLY  = 3;                        // stop delay select

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;            // control, write pulses
  localparam logic [7:0] REG_STATE    = 8'h04;            // live state, read only
  localparam logic [7:0] REG_SWITCH   = 8'h08;            // synced switches, read only
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;            // sticky events, write 1 clears
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;            // interrupt enables
  localparam logic [7:0] REG_ELAPSED  = 8'h14;            // stop timer ms count

  // field positions
  localparam int CTRL_RESTART = 0;                        // re-energise stop relay
  localparam int ST_ANY       = 8;                        // any zone in alarm
  localparam int ST_RELAY     = 9;                        // alarm relay in alarm state
  localparam int ST_TRIPPED   = 10;                       // stop relay dropped
  localparam int ST_RUN       = 11;                       // stop timer running
  localparam int IRQ_W        = 3;                        // number of event bits

  // reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;       // all events masked
  localparam logic [ZONES-1:0] ZONE_RST     = 8'hff;      // inputs idle high
  localparam logic [SWITCH-1:0] SWITCH_RST  = 8'h00;      // shipped: all off

  // decoded configuration
  typedef struct packed {
    logic long_delay;                                     // 180 s stop delay
    logic opt_inv;                                        // option relay idle off
    logic relay_inv;                                      // alarm relay idle on
    logic input_high;                                     // alarm when input high
  } mzam_cfg_t;

  // one-cycle events feeding the sticky status
  typedef struct packed {
    logic trip;                                           // stop relay dropped
    logic clear;                                          // last alarm went away
    logic raise;                                          // first alarm arrived
  } mzam_evt_t;

endpackage

// [mzam_sync.sv]
// two-flop synchroniser for a bus of asynchronous pins
`timescale 1ns/100ps
module mzam_sync #(
  parameter int              W       = 8,                 // number of bits
  parameter logic [W-1:0]    RST_VAL = '0                 // value held in reset
) (
  input  wire logic          clk_i,                       // system clock
  input  wire logic          rst_i,                       // sync reset, high
  input  wire logic [W-1:0]  d_i,                         // raw pins
  output logic      [W-1:0]  q_o                          // synchronised copy
);

  logic [W-1:0] meta;                                     // first stage, read only by q_o

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // mzam_sync

// [mzam_monitor.sv]
// eight-zone alarm monitor: zone sensing, relays, stop timer, wishbone registers
// Summary of operation
// - any of eight zones alarming raises alarm
// - switch off: input low means alarm
// - switch on: input high means alarm
// - switch off: alarm relay energises on alarm
// - switch on: alarm relay de-energises on alarm
// - switch off: option relay drops on alarm
// - switch on: option relay energises on alarm
// - stop relay drops sixty seconds after alarm
// - switch on: stop relay drops after 180 s
// - switch right position reads as on
// - switches five to eight do nothing
// - all switches off gives the fail-safe defaults
// - lamps at once, alarm relay one second later
// - all clear: lamps off, relay back immediately
`timescale 1ns/100ps
module mzam_monitor #(
  parameter int TICK_CYCLES    = mzam_pkg::TICK_CYCLES,   // cycles per ms tick
  parameter int ALARM_DELAY_MS = mzam_pkg::ALARM_DELAY_MS, // alarm relay lag
  parameter int STOP_SHORT_MS  = mzam_pkg::STOP_SHORT_MS, // short stop delay
  parameter int STOP_LONG_MS   = mzam_pkg::STOP_LONG_MS   // long stop delay
) (
  input  wire logic                       clk_i,          // 200 MHz clock
  input  wire logic                       rst_i,          // sync reset, high
  input  wire logic [mzam_pkg::ZONES-1:0] zone_i,         // opto-isolated inputs
  input  wire logic [mzam_pkg::SWITCH-1:0] switch_i,      // switch block, on = 1
  output logic      [mzam_pkg::ZONES-1:0] zone_lamp_o,    // per-zone lamps
  output logic                            alarm_lamp_o,   // common alarm lamp
  output logic                            alarm_relay_o,  // alarm relay coil
  output logic                            opt_relay_o,    // option board relays
  output logic                            stop_relay_o,   // machine stop relay coil
  output logic                            irq_o,          // level interrupt
  input  wire logic                       wb_cyc_i,       // wishbone cycle
  input  wire logic                       wb_stb_i,       // wishbone strobe
  input  wire logic                       wb_we_i,        // write enable
  input  wire logic [7:0]                 wb_adr_i,       // byte address
  input  wire logic [3:0]                 wb_sel_i,       // byte lanes
  input  wire logic [31:0]                wb_dat_i,       // write data
  output logic      [31:0]                wb_dat_o,       // read data
  output logic                            wb_ack_o        // acknowledge
);

  localparam logic [mzam_pkg::TICK_W-1:0] TICK_LAST =
    mzam_pkg::TICK_W'(TICK_CYCLES - 1);                   // divider wrap value
  localparam logic [mzam_pkg::CNT_W-1:0] DLY_LAST =
    mzam_pkg::CNT_W'(ALARM_DELAY_MS - 1);                 // relay lag in ticks, less one
  localparam logic [mzam_pkg::CNT_W-1:0] SHORT_LAST =
    mzam_pkg::CNT_W'(STOP_SHORT_MS - 1);                  // short stop limit
  localparam logic [mzam_pkg::CNT_W-1:0] LONG_LAST =
    mzam_pkg::CNT_W'(STOP_LONG_MS - 1);                   // long stop limit

  logic [mzam_pkg::ZONES-1:0]  zone_s;                    // synced inputs
  logic [mzam_pkg::SWITCH-1:0] sw_s;                      // synced switches
  mzam_pkg::mzam_cfg_t         cfg;                       // decoded switches
  logic [mzam_pkg::ZONES-1:0]  zone_alarm;                // per-zone alarm, live
  logic                        any_alarm;                 // any zone alarming
  logic                        any_q;                     // any_alarm last cycle
  logic [mzam_pkg::TICK_W-1:0] tick_cnt;                  // ms divider
  logic                        tick;                      // one-cycle ms pulse
  logic [mzam_pkg::CNT_W-1:0]  dly_cnt;                   // alarm relay lag counter
  logic                        relay_act;                 // relay in alarm state
  logic [mzam_pkg::CNT_W-1:0]  stop_cnt;                  // stop timer, ms elapsed
  logic [mzam_pkg::CNT_W-1:0]  stop_last;                 // selected limit
  logic                        stop_run;                  // stop timer counting
  logic                        tripped;                   // stop relay dropped
  mzam_pkg::mzam_evt_t         evt;                       // events this cycle
  logic [mzam_pkg::IRQ_W-1:0]  irq_stat;                  // sticky events
  logic [mzam_pkg::IRQ_W-1:0]  irq_mask;                  // event enables
  logic                        wb_req;                    // request pending
  logic                        wb_wr;                     // write taking effect
  logic [31:0]                 next_rdata;                // decoded read word

  // pins come from outside the clock domain
  mzam_sync #(
    .W       (mzam_pkg::ZONES),
    .RST_VAL (mzam_pkg::ZONE_RST)
  ) u_zone_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (zone_i),
    .q_o   (zone_s)
  );

  // switches may be moved live, so they are synced too
  mzam_sync #(
    .W       (mzam_pkg::SWITCH),
    .RST_VAL (mzam_pkg::SWITCH_RST)
  ) u_sw_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (switch_i),
    .q_o   (sw_s)
  );

  // only the first four switches are decoded; the rest are readback only
  always_comb begin
    cfg.input_high = sw_s[mzam_pkg::SW_IN_POL];
    cfg.relay_inv  = sw_s[mzam_pkg::SW_RELAY_POL];
    cfg.opt_inv    = sw_s[mzam_pkg::SW_OPT_POL];
    cfg.long_delay = sw_s[mzam_pkg::SW_STOP_DLY];
  end

  // off: idle high, alarm low; on: idle low, alarm high
  always_comb begin
    if (cfg.input_high) begin
      zone_alarm = zone_s;
    end else begin
      zone_alarm = ~zone_s;
    end
    any_alarm = |zone_alarm;
  end

  // millisecond tick divider keeps long counters narrow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // lamps follow the zones with no delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zone_lamp_o  <= '0;
      alarm_lamp_o <= 1'b0;
      any_q        <= 1'b0;
    end else begin
      zone_lamp_o  <= zone_alarm;
      alarm_lamp_o <= any_alarm;
      any_q        <= any_alarm;
    end
  end

  // relay lag: about one second, quantised to the ms tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_cnt   <= '0;
      relay_act <= 1'b0;
    end else if (!any_alarm) begin
      dly_cnt   <= '0;
      relay_act <= 1'b0;
    end else if (tick && !relay_act) begin
      if (dly_cnt == DLY_LAST) begin
        relay_act <= 1'b1;
      end else begin
        dly_cnt <= dly_cnt + 1'b1;
      end
    end
  end

  // limit picked live from the delay switch
  assign stop_last = cfg.long_delay ? LONG_LAST : SHORT_LAST;

  // stop timer: armed by a new alarm, cancelled if all clears in time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_cnt <= '0;
      stop_run <= 1'b0;
    end else if (any_alarm && !any_q && !tripped) begin
      stop_cnt <= '0;
      stop_run <= 1'b1;
    end else if (!any_alarm) begin
      stop_run <= 1'b0;
    end else if (stop_run && tick) begin
      if (stop_cnt >= stop_last) begin
        stop_run <= 1'b0;
      end else begin
        stop_cnt <= stop_cnt + 1'b1;
      end
    end
  end

  // trip latch; only software brings the machine back, and only when clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tripped <= 1'b0;
    end else if (stop_run && any_alarm && tick && stop_cnt >= stop_last) begin
      tripped <= 1'b1;
    end else if (wb_wr && wb_adr_i == mzam_pkg::REG_CTRL && wb_sel_i[0] &&
                 wb_dat_i[mzam_pkg::CTRL_RESTART] && !any_alarm) begin
      tripped <= 1'b0;
    end
  end

  // relay coils; polarities applied on the way out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_relay_o <= 1'b0;
      opt_relay_o   <= 1'b0;
      stop_relay_o  <= 1'b0;
    end else begin
      alarm_relay_o <= relay_act ^ cfg.relay_inv;
      opt_relay_o   <= any_alarm ~^ cfg.opt_inv;
      stop_relay_o  <= !tripped;
    end
  end

  // events for the interrupt block
  assign evt.raise = any_alarm && !any_q;
  assign evt.clear = !any_alarm && any_q;
  assign evt.trip  = stop_run && any_alarm && tick && stop_cnt >= stop_last;

  // sticky status: a new event beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wb_wr && wb_adr_i == mzam_pkg::REG_IRQ_STAT && wb_sel_i[0]) begin
      irq_stat <= (irq_stat & ~wb_dat_i[mzam_pkg::IRQ_W-1:0]) | evt;
    end else begin
      irq_stat <= irq_stat | evt;
    end
  end

  // mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= mzam_pkg::IRQ_MASK_RST;
    end else if (wb_wr && wb_adr_i == mzam_pkg::REG_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask <= wb_dat_i[mzam_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);                  // level while unmasked set

  // one wait state; the write lands at the edge the master sees ack
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;

  // read decode; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      mzam_pkg::REG_STATE: begin
        next_rdata[mzam_pkg::ZONES-1:0] = zone_alarm;
        next_rdata[mzam_pkg::ST_ANY]     = any_alarm;
        next_rdata[mzam_pkg::ST_RELAY]   = relay_act;
        next_rdata[mzam_pkg::ST_TRIPPED] = tripped;
        next_rdata[mzam_pkg::ST_RUN]     = stop_run;
      end
      mzam_pkg::REG_SWITCH:   next_rdata[mzam_pkg::SWITCH-1:0] = sw_s;
      mzam_pkg::REG_IRQ_STAT: next_rdata[mzam_pkg::IRQ_W-1:0] = irq_stat;
      mzam_pkg::REG_IRQ_MASK: next_rdata[mzam_pkg::IRQ_W-1:0] = irq_mask;
      mzam_pkg::REG_ELAPSED:  next_rdata[mzam_pkg::CNT_W-1:0] = stop_cnt;
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  // ack and read data registered together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ---- checks ----
  sequence s_clear_hit;
    wb_wr && wb_adr_i == mzam_pkg::REG_IRQ_STAT && wb_sel_i[0] && wb_dat_i[0];
  endsequence

  property p_lamp_follow;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (zone_lamp_o == $past(zone_alarm)) && (alarm_lamp_o == |zone_lamp_o);
  endproperty
  a_lamp_follow: assert property (p_lamp_follow) else $error("lamps wrong");

  property p_in_pol;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> zone_lamp_o == ($past(zone_s) ^ {mzam_pkg::ZONES{!$past(cfg.input_high)}});
  endproperty
  a_in_pol: assert property (p_in_pol) else $error("input polarity wrong");

  property p_relay_idle;
    @(posedge clk_i) disable iff (rst_i)
      !$past(relay_act) && !$past(rst_i) |-> alarm_relay_o == $past(cfg.relay_inv);
  endproperty
  a_relay_idle: assert property (p_relay_idle) else $error("relay idle wrong");

  property p_relay_lag;
    @(posedge clk_i) disable iff (rst_i)
      $rose(relay_act) |-> $past(tick) && $past(dly_cnt) == DLY_LAST && $past(any_alarm);
  endproperty
  a_relay_lag: assert property (p_relay_lag) else $error("relay lag wrong");

  property p_relay_clear;
    @(posedge clk_i) disable iff (rst_i)
      !any_alarm |=> !relay_act ##1 alarm_relay_o == $past(cfg.relay_inv);
  endproperty
  a_relay_clear: assert property (p_relay_clear) else $error("relay not released");

  property p_opt_pol;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> opt_relay_o == (alarm_lamp_o ~^ $past(cfg.opt_inv));
  endproperty
  a_opt_pol: assert property (p_opt_pol) else $error("option relay wrong");

  property p_stop_trip;
    @(posedge clk_i) disable iff (rst_i)
      $rose(tripped) |-> $past(stop_cnt) == $past(stop_last) ##1 !stop_relay_o;
  endproperty
  a_stop_trip: assert property (p_stop_trip) else $error("stop trip time wrong");

  property p_stop_hold;
    @(posedge clk_i) disable iff (rst_i)
      !tripped && !$past(tripped) && !$past(rst_i) |-> stop_relay_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop relay dropped early");

  property p_no_restart;
    @(posedge clk_i) disable iff (rst_i)
      stop_run && $past(stop_run) |-> stop_cnt == $past(stop_cnt) ||
                                      stop_cnt == $past(stop_cnt) + 1'b1;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("stop timer restarted");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      s_clear_hit ##0 evt.raise |=> irq_stat[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

endmodule // mzam_monitor

// [mzam_field.sv]
// field-side model: sensors wired to the zone pins
`timescale 1ns/100ps
module mzam_field (
  input  wire logic       clk_i,     // system clock, for a slow sensor
  input  wire logic [7:0] alarm_i,   // which sensors report alarm
  input  wire logic       high_i,    // wiring: alarm drives pin high
  input  wire logic       slow_i,    // sensor answers one cycle late
  output logic      [7:0] zone_o     // pin levels seen by the core
);
  logic [7:0] late;                  // delayed sensor copy
  // a slow sensor lags its contact by one clock
  always_ff @(posedge clk_i) begin
    late <= alarm_i;
  end
  // fail-safe wiring drives low on alarm, else high on alarm
  assign zone_o = high_i ? (slow_i ? late : alarm_i) : ~(slow_i ? late : alarm_i);
endmodule // mzam_field

// [test_multi_zone_alarm_monitor.sv]
// self-checking bench for the eight-zone alarm monitor core
`timescale 1ns/100ps
module test_multi_zone_alarm_monitor;
  typedef struct packed {
    logic [7:0] sw;                 // switch block
    logic [7:0] alm;                // sensors in alarm
    logic       rly;                // expected alarm relay coil
    logic       opt;                // expected option relay coil
  } mzam_row_t;
  logic        clk_i = 1'b0;        // 200 MHz clock
  logic        rst_i = 1'b1;        // sync reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;         // byte address
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [7:0]  sw = 8'h00, alm = 8'h00, pins, lamp;
  logic        alamp, arly, orly, srly, irq, ack;
  int          bad_count = 0, num_checks = 0, n;
  // ordinary cases: switches and sensors beside relay coils
  mzam_row_t rows [10] = '{'{8'h00, 8'h01, 1'b1, 1'b0}, '{8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h01, 8'h80, 1'b1, 1'b0}, '{8'h02, 8'h10, 1'b0, 1'b0}, '{8'h02, 8'h00, 1'b1, 1'b1},
    '{8'h04, 8'h24, 1'b1, 1'b1}, '{8'h04, 8'h00, 1'b0, 1'b0}, '{8'hf0, 8'hff, 1'b1, 1'b0},
    '{8'hf7, 8'h00, 1'b1, 1'b0}, '{8'hf9, 8'h42, 1'b1, 1'b0}};
  always #2.5 clk_i = ~clk_i;
  // sensors, only the first row answers late (bus address bit 2 set)
  mzam_field field (.clk_i(clk_i), .alarm_i(alm), .high_i(sw[0]), .slow_i(adr[2]),
    .zone_o(pins));
  // short counts keep the run brief: 4 cycles a tick, 3/5/9 ticks
  mzam_monitor #(.TICK_CYCLES(4), .ALARM_DELAY_MS(3), .STOP_SHORT_MS(5), .STOP_LONG_MS(9)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .zone_i(pins), .switch_i(sw), .zone_lamp_o(lamp),
    .alarm_lamp_o(alamp), .alarm_relay_o(arly), .opt_relay_o(orly), .stop_relay_o(srly),
    .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one classic cycle; ack sampled at the edge, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 50) begin
      bad_count++;
      close_out();
    end
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // counts edges until a watched output takes a level
  task automatic wait_for(input int which, input logic v, inout int c);
    logic s;
    s = ~v;
    while (s !== v && c < 400) begin
      @(posedge clk_i);
      c++;
      case (which)
        0: s = alamp;
        1: s = arly;
        default: s = srly;
      endcase
    end
  endtask
  // watchdog at twenty thousand cycles, run is under a thousand cycles
  initial begin
    #(20000 * 5);
    bad_count++;
    close_out();
  end
  initial begin
    wt(10);
    rst_i <= 1'b0;
    wt(5);
    chk_pin(lamp, 8'h00);
    chk_pin({alamp, arly, orly, srly, irq}, 5'b00110);
    wb(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h0);
    // live state and switch readback are quiet after reset
    wb(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk_reg(rd, 32'h0);
    wb(1'b1, 8'h3c, 32'hff);
    wb(1'b0, 8'h3c, 32'h0);
    chk_reg(rd, 32'h0);
    $display("reset test done");
    // table rows, each clears and restarts the stop relay after
    foreach (rows[i]) begin
      sw <= rows[i].sw; alm <= rows[i].alm;
      wt(28);
      chk_pin(lamp, rows[i].alm);
      chk_pin({alamp, arly, orly}, {|rows[i].alm, rows[i].rly, rows[i].opt});
      alm <= 8'h00;
      wt(12);
      chk_pin({alamp, arly}, {1'b0, rows[i].sw[1]});
      wb(1'b1, 8'h00, 32'h1);
      wt(3);
      chk_pin(srly, 1'b1);
    end
    $display("table test done");
    // lamp at once, relay later, stop on the short delay
    sw <= 8'h00; alm <= 8'h08; n = 0;
    wait_for(0, 1'b1, n);
    chk_pin(n <= 5, 1'b1);
    wait_for(1, 1'b1, n);
    chk_pin(n >= 8 && n <= 22, 1'b1);
    alm <= 8'h0c;
    wait_for(2, 1'b0, n);
    chk_pin(n >= 18 && n <= 32, 1'b1);
    $display("short stop test done");
    // sticky events, mask and write-one clear
    wb(1'b0, 8'h0c, 32'h0);
    chk_reg(rd, 32'h7);
    chk_pin(irq, 1'b0);
    wb(1'b1, 8'h10, 32'h4);
    wt(2);
    chk_pin(irq, 1'b1);
    wb(1'b1, 8'h0c, 32'h7);
    wt(2);
    chk_pin(irq, 1'b0);
    wb(1'b1, 8'h00, 32'h1);
    wt(3);
    chk_pin(srly, 1'b0);
    // zones 2,3, any, relay in alarm, tripped, timer stopped
    wb(1'b0, 8'h04, 32'h0);
    chk_reg(rd, 32'h0000_070c);
    // timer parked at the short limit, four ticks with the bench counts
    wb(1'b0, 8'h14, 32'h0);
    chk_reg(rd, 32'h0000_0004);
    alm <= 8'h00;
    wt(12);
    wb(1'b0, 8'h0c, 32'h0);
    chk_reg(rd, 32'h2);
    wb(1'b1, 8'h10, 32'h7);
    wb(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h7);
    chk_pin(irq, 1'b1);
    wb(1'b1, 8'h0c, 32'h2);
    wt(2);
    chk_pin(irq, 1'b0);
    wb(1'b1, 8'h00, 32'h1);
    wt(3);
    chk_pin(srly, 1'b1);
    $display("interrupt test done");
    // long delay, then a brief alarm that must not trip
    sw <= 8'h08; alm <= 8'h01; n = 0;
    wait_for(2, 1'b0, n);
    chk_pin(n >= 36 && n <= 50, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    chk_reg(rd, 32'h0000_0008);
    alm <= 8'h00;
    wt(12);
    wb(1'b1, 8'h00, 32'h1);
    alm <= 8'h01;
    wt(8);
    alm <= 8'h00;
    wt(60);
    chk_pin(srly, 1'b1);
    $display("long stop test done");
    close_out();
  end
endmodule // test_multi_zone_alarm_monitor
